// [hdl/sbsr_map.vh]
/*
 Register layout, bit positions and reset values of the status byte
 and service request logic. Definitions only.
*/
`ifndef SBSR_MAP_VH
`define SBSR_MAP_VH

`define SBSR_BIT_INTERNAL   0
`define SBSR_BIT_RSVD_ONE   1
`define SBSR_BIT_ADJUSTED   2
`define SBSR_BIT_RSVD_THREE 3
`define SBSR_BIT_QUEUE      4
`define SBSR_BIT_STD_EVENT  5
`define SBSR_BIT_SUMMARY    6
`define SBSR_BIT_RSVD_SEVEN 7

`define SBSR_MASK_WRITABLE  8'hBF
`define SBSR_MASK_RESET     8'h00
`define SBSR_FLAG_RESET     1'b0
`define SBSR_BYTE_RESET     8'h00
`define SBSR_STATUS_IDLE    8'h00

`endif

// [hdl/sbsr_status_byte.v]
/*
 Status summary byte and service request logic.
 Gathers the four summary sources into one byte, gates them with the
 request enable mask and drives a service request level.
 Assumes every input is synchronous to core_clk. The event sources
 give one-cycle pulses for adjusted values and internal state entries,
 and a clear pulse when the matching event register is read or cleared.
 The standard event summary and queue state arrive as levels.
 Limitation: the standard event summary is not held here; the event
 register must keep it up until that register is read or cleared.
 The mask readback and both status bytes are registered and trail
 the state they report by one clock, except poll byte bit 6, which
 matches the request flag in the same cycle.
*/
`timescale 1ns/1ps
`include "sbsr_map.vh"

module sbsr_status_byte (
    core_clk,
    nrst,
    mask_wr,
    mask_wdata,
    mask_rdata,
    standard_event_summary,
    output_queue_nonempty,
    value_adjusted_set,
    value_adjusted_clr,
    internal_state_set,
    internal_state_clr,
    poll_done,
    query_byte,
    poll_byte,
    master_summary_bit,
    request_service_flag,
    service_request
);
    input  wire       core_clk;
    input  wire       nrst;
    input  wire       mask_wr;
    input  wire [7:0] mask_wdata;
    output wire [7:0] mask_rdata;
    input  wire       standard_event_summary;
    input  wire       output_queue_nonempty;
    input  wire       value_adjusted_set;
    input  wire       value_adjusted_clr;
    input  wire       internal_state_set;
    input  wire       internal_state_clr;
    input  wire       poll_done;
    output wire [7:0] query_byte;
    output wire [7:0] poll_byte;
    output wire       master_summary_bit;
    output wire       request_service_flag;
    output wire       service_request;

    // Sticky flag slots; both slots behave the same way
    localparam FLAG_COUNT = 2;
    localparam FLAG_ADJ   = 0;
    localparam FLAG_INT   = 1;
    localparam BYTE_W     = 8;

    reg  [7:0] request_enable_mask_r;
    reg  [7:0] request_enable_mask_nxt;
    reg  [1:0] sticky_flag_r;
    wire [1:0] sticky_flag_nxt;
    wire [1:0] sticky_set;
    wire [1:0] sticky_clr;
    reg        request_service_flag_r;
    reg        request_service_flag_nxt;
    reg  [7:0] status_summary_byte;
    wire [7:0] masked_status;
    reg  [7:0] mask_rdata_r;
    reg  [7:0] query_byte_r;
    reg  [7:0] query_nxt;
    reg  [7:0] poll_byte_r;
    reg  [7:0] poll_nxt;

    genvar g;

    // Set beats clear so an event in the clearing cycle is kept
    function sticky_next;
        input cur;
        input set;
        input clr;
        begin
            sticky_next = set | (cur & ~clr);
        end
    endfunction

    // Both read paths share the status byte and differ only in bit 6
    function [7:0] place_bit_six;
        input [7:0] base;
        input       bit_six;
        begin
            place_bit_six = base;
            place_bit_six[`SBSR_BIT_SUMMARY] = bit_six;
        end
    endfunction

    // Slot order must match FLAG_ADJ and FLAG_INT
    assign sticky_set[FLAG_ADJ] = value_adjusted_set;
    assign sticky_set[FLAG_INT] = internal_state_set;
    assign sticky_clr[FLAG_ADJ] = value_adjusted_clr;
    assign sticky_clr[FLAG_INT] = internal_state_clr;

    generate
        for (g = 0; g < FLAG_COUNT; g = g + 1) begin : gen_sticky
            assign sticky_flag_nxt[g] = sticky_next(sticky_flag_r[g],
                sticky_set[g], sticky_clr[g]);
        end
        // A zero mask bit holds its status bit out of the summary
        for (g = 0; g < BYTE_W; g = g + 1) begin : gen_masked
            assign masked_status[g] = status_summary_byte[g] &
                request_enable_mask_r[g];
        end
    endgenerate

    // Reserved positions and bit 6 stay at the idle value here;
    // bit 6 is filled in per read path
    always @* begin
        status_summary_byte = `SBSR_STATUS_IDLE;
        status_summary_byte[`SBSR_BIT_STD_EVENT] =
            standard_event_summary;
        status_summary_byte[`SBSR_BIT_QUEUE] =
            output_queue_nonempty;
        status_summary_byte[`SBSR_BIT_ADJUSTED] =
            sticky_flag_r[FLAG_ADJ];
        status_summary_byte[`SBSR_BIT_INTERNAL] =
            sticky_flag_r[FLAG_INT];
    end

    // An all-zero mask leaves every masked bit low
    assign master_summary_bit = |masked_status;

    // Level output, no latch: it drops in the same cycle as the summary
    assign service_request = master_summary_bit;

    // Bit 6 is dropped on the way in, so it can never feed the summary
    always @* begin
        request_enable_mask_nxt = request_enable_mask_r;
        if (mask_wr) begin
            request_enable_mask_nxt =
                mask_wdata & `SBSR_MASK_WRITABLE;
        end
    end

    // Request flag rises with a request and drops once polled; a poll
    // that ends while the summary is still high leaves it set
    always @* begin
        request_service_flag_nxt = request_service_flag_r;
        if (poll_done) begin
            request_service_flag_nxt = 1'b0;
        end
        if (master_summary_bit) begin
            request_service_flag_nxt = 1'b1;
        end
    end

    // The poll byte takes the flag's next value so both outputs agree
    // in every cycle
    always @* begin
        query_nxt = place_bit_six(status_summary_byte,
            master_summary_bit);
        poll_nxt = place_bit_six(status_summary_byte,
            request_service_flag_nxt);
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            request_enable_mask_r <= `SBSR_MASK_RESET;
        end else begin
            request_enable_mask_r <= request_enable_mask_nxt;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sticky_flag_r <= {FLAG_COUNT{`SBSR_FLAG_RESET}};
        end else begin
            sticky_flag_r <= sticky_flag_nxt;
        end
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            request_service_flag_r <= `SBSR_FLAG_RESET;
        end else begin
            request_service_flag_r <= request_service_flag_nxt;
        end
    end

    // Read data is registered, so it trails the mask by one cycle
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mask_rdata_r <= `SBSR_MASK_RESET;
            query_byte_r <= `SBSR_BYTE_RESET;
            poll_byte_r  <= `SBSR_BYTE_RESET;
        end else begin
            mask_rdata_r <= request_enable_mask_r;
            query_byte_r <= query_nxt;
            poll_byte_r  <= poll_nxt;
        end
    end

    assign mask_rdata           = mask_rdata_r;
    assign query_byte           = query_byte_r;
    assign poll_byte            = poll_byte_r;
    assign request_service_flag = request_service_flag_r;
endmodule

// [verification/sbsr_partner.sv]
/* Poll partner. Assumes go comes as a one-cycle pulse. */
`timescale 1ns/1ps
module sbsr_partner (
    input  wire core_clk,
    input  wire go,
    output reg  poll_done = 1'b0
);
    always @(posedge core_clk) poll_done <= go; // End poll after byte read
endmodule

// [verification/sbsr_properties.sv]
/* Port checker. Assumes the core_clk domain only. */
`timescale 1ns/1ps
module sbsr_properties (
    input wire core_clk, nrst, mask_wr, value_adjusted_set, service_request,
    input wire master_summary_bit, request_service_flag,
    input wire [7:0] mask_wdata, mask_rdata, query_byte, poll_byte
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_mask_back: assert property (mask_wr |-> ##2
        mask_rdata == ($past(mask_wdata, 2) & 8'hBF)) else $error("mask");
    a_mask_six: assert property (!mask_rdata[6]) else $error("six");
    a_rsvd_zero: assert property (!(8'h8A & (query_byte | poll_byte)))
        else $error("rsvd");
    a_query_summary: assert property (query_byte[6] ==
        $past(master_summary_bit)) else $error("query");
    a_poll_request: assert property (poll_byte[6] ==
        request_service_flag) else $error("poll");
    a_summary_or: assert property (query_byte[6] ==
        |(query_byte & mask_rdata & 8'hBF)) else $error("summary");
    a_srq_level: assert property (service_request ==
        master_summary_bit) else $error("srq");
    a_zero_mask: assert property (!mask_rdata && !$past(mask_wr)
        |-> !service_request) else $error("zero");
    a_adj_set: assert property (value_adjusted_set |-> ##2
        query_byte[2]) else $error("adjust");
endmodule
bind sbsr_status_byte sbsr_properties sbsr_properties_i (.*);

// [verification/tb_top.sv]
/* Status byte bench. Assumes the partner ends each poll. */
`timescale 1ns/1ps
module tb_top;
    reg core_clk = 0, nrst = 0, go = 0, mask_wr = 0;
    reg value_adjusted_set = 0, internal_state_set = 0;
    reg standard_event_summary = 0, output_queue_nonempty = 0;
    reg [7:0] mask_wdata = 0, st, ev, f;
    reg [15:0] q[$], x;
    wire [7:0] mask_rdata, query_byte, poll_byte;
    wire poll_done, master_summary_bit, request_service_flag, service_request;
    // Mask writes clear the sticky flags; a same-cycle set wins
    wire value_adjusted_clr = mask_wr, internal_state_clr = mask_wr;
    integer errors = 0, checked = 0, cyc = 0, i;
    sbsr_status_byte sbsr_status_byte_i (.*);
    sbsr_partner sbsr_partner_i (.*);
    initial forever #10 core_clk = ~core_clk;
    task cmp(input [8*5:1] n, input [7:0] e, input [7:0] g);
        checked = checked + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("[ERR] %0s exp %h got %h", n, e, g);
        end
    endtask
    task conclude;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (go && !mask_wr) begin
            x = q.pop_front();
            f = {5'h00, master_summary_bit, request_service_flag,
                service_request};
            cmp("query", x[7:0], query_byte);
            cmp("poll", x[7:0], poll_byte);
            cmp("mask", x[15:8], mask_rdata);
            cmp("srq", {5'h00, {3{x[6]}}}, f);
        end
        if (cyc > 3000) begin
            errors = errors + 1;
            conclude;
        end
    end
    initial begin
        i = $urandom(32679);
        repeat (20) @(posedge core_clk);
        #1 nrst = 1;
        for (i = 0; i < 40; i = i + 1) begin
            mask_wdata = i < 2 ? {8{i == 0}} : $urandom;
            st = $urandom & 8'h35;
            ev = st | {|(st & mask_wdata & 8'hBF), 6'h00};
            q.push_back({mask_wdata & 8'hBF, ev});
            // The first poll settles the request flag to the new summary
            @(posedge core_clk) #1 {mask_wr, go, standard_event_summary,
                output_queue_nonempty, value_adjusted_set,
                internal_state_set} = {2'h3, st[5:4], st[2], st[0]};
            @(posedge core_clk) #1 {mask_wr, go, value_adjusted_set,
                internal_state_set} = 4'h0;
            repeat (3) @(posedge core_clk);
            #1 go = 1;
            @(posedge core_clk) #1 go = 0;
        end
        conclude;
    end
endmodule
